// ### lhr_pkg.sv
/*
  Constants, register indices and state types for the LAPD receive framer.
  Assumes an AXI4-Lite master with 32-bit data and a 200 MHz system clock.
*/
`default_nettype none
package lhr_pkg;
  localparam int          ADDR_W      = 8;
  localparam logic [5:0]  IDX_FIFO_LAST = 6'h1f;
  localparam logic [5:0]  IDX_CHAN    = 6'h20;
  localparam logic [5:0]  IDX_MODE    = 6'h21;
  localparam logic [5:0]  IDX_SAPI_MATCH_FIRST    = 6'h22;
  localparam logic [5:0]  IDX_SAPI_MATCH_SECOND    = 6'h23;
  localparam logic [5:0]  IDX_TEI_MATCH_FIRST    = 6'h24;
  localparam logic [5:0]  IDX_TEI_MATCH_SECOND    = 6'h25;
  localparam logic [5:0]  IDX_EXTENDED_FIFO_CONFIG    = 6'h26;
  localparam logic [5:0]  IDX_ISTAT   = 6'h27;
  localparam logic [5:0]  IDX_CMD     = 6'h28;
  localparam logic [5:0]  IDX_CNTL    = 6'h29;
  localparam logic [5:0]  IDX_CNTH    = 6'h2a;
  localparam logic [2:0]  CHAN_RST    = 3'h1;
  localparam logic [2:0]  MODE_RST    = 3'h3;
  localparam logic [1:0]  BLK_RST     = 2'h0;
  localparam logic [5:0]  BLK_MAX     = 6'h20;
  localparam logic [6:0]  FIFO_BYTES  = 7'h40;
  localparam logic [11:0] CNT_MAX     = 12'hfff;
  localparam logic [7:0]  FLAG        = 8'h7e;
  localparam logic [7:0]  SAPI_MASK   = 8'hfd;
  localparam logic [7:0]  GRP_SAPI    = 8'hfc;
  localparam logic [6:0]  GRP_TEI     = 7'h7f;
  localparam logic [2:0]  STUFF_ONES  = 3'h5;
  localparam logic [2:0]  ABORT_ONES  = 3'h6;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_GOOD    = 16'hf0b8;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam int          IS_RFO = 0, IS_RME = 1, IS_RPF = 2;
  localparam int          CMD_RMC = 0, CMD_RX_RESET_CMD = 1;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLV    = 2'h2;
  typedef enum logic [2:0] {MD_EXT = 3'b100, MD_TEI = 3'b101, MD_ONE = 3'b010,
    MD_TWO = 3'b011, MD_TRANS = 3'b110, MD_SAPI = 3'b111} lhr_mode_type;
  typedef enum logic [1:0] {END_IDLE = 2'b00, END_CRC1 = 2'b01, END_CRC2 = 2'b10,
    END_STAT = 2'b11} lhr_end_type;
endpackage : lhr_pkg
`default_nettype wire

// ### lhr_receiver.sv
/*
  LAPD receive framer: bit deframing, address filter, 64-byte cyclic FIFO,
  block indication queue and an AXI4-Lite register slave.
  Assumes serial bits come from timeslot logic on clk, strobes at least two clocks apart.
*/
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lhr_receiver #(
  parameter int QDEPTH = 16
) (
  input  wire logic                      clk,
  input  wire logic                      reset_n,
  input  wire logic                      serBit,
  input  wire logic                      serBitStrobe,
  input  wire logic [1:0]                serSlot,
  input  wire logic [lhr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [lhr_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import lhr_pkg::*;
  localparam int QW = $clog2(QDEPTH);

  // Bit-serial CRC, LSB first, as the line delivers it.
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crcByte

  logic [2:0]  chanEn_reg;
  logic [2:0]  mode_reg;
  logic [7:0]  sapi_match_first_reg, sapi_match_second_reg, tei_match_first_reg, tei_match_second_reg;
  logic [1:0]  blkSel_reg;
  logic [5:0]  blkSize_reg;
  logic [2:0]  istat_reg;
  logic [7:0]  rawSh_reg, byteSh_reg, d0_reg, d1_reg, lastByte_reg;
  logic [2:0]  ones_reg, bitCnt_reg;
  logic [1:0]  dCnt_reg, idx_reg;
  logic [15:0] crc_reg;
  logic        inFrame_reg, addrPass_reg, stVfr_reg, stCrc_reg, stAbort_reg;
  lhr_end_type endState_reg;
  logic [7:0]  mem_reg [64];
  logic [6:0]  wrPtr_reg, rdPtr_reg, relPtr_reg;
  logic [5:0]  segCnt_reg, curLen_reg;
  logic [11:0] frameCnt_reg, cnt_reg;
  logic        frameOv_reg, cntOv_reg, started_reg, frameDrop_reg, rdo_reg;
  logic        presented_reg, curEnd_reg;
  logic [QW:0] qWr_reg, qRd_reg;
  logic        qEnd_reg [QDEPTH];
  logic        qOv_reg  [QDEPTH];
  logic [5:0]  qLen_reg [QDEPTH];
  logic [11:0] qCnt_reg [QDEPTH];
  logic        awHeld_reg, wHeld_reg;
  logic [5:0]  awIdx_reg;
  logic [7:0]  wData_reg;
  logic [1:0]  wCmd_reg;
  logic        wLane_reg;

  // Register-port decode; the FIFO answers on all of its 32 word slots.
  logic [5:0] arIdx;
  logic       doRead, doWrite, fifoRd, istatRd, cmdRmc, cmdRres, canRead, wrMapped;
  assign arIdx    = s_axi_araddr[7:2];
  assign doRead   = s_axi_arvalid && s_axi_arready;
  assign doWrite  = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign fifoRd   = doRead && (arIdx <= IDX_FIFO_LAST);
  assign istatRd  = doRead && (arIdx == IDX_ISTAT);
  assign cmdRmc   = doWrite && wLane_reg && awIdx_reg == IDX_CMD && wCmd_reg[CMD_RMC];
  assign cmdRres  = doWrite && wLane_reg && awIdx_reg == IDX_CMD && wCmd_reg[CMD_RX_RESET_CMD];
  assign wrMapped = awIdx_reg >= IDX_CHAN && awIdx_reg <= IDX_CMD;
  assign canRead  = rdPtr_reg != wrPtr_reg &&
                    (!presented_reg || (rdPtr_reg - relPtr_reg) < {1'b0, curLen_reg});

  // Line side: channel gate, flag, abort and stuffing recognition.
  logic       bitOk, modeHdlc, isFlag, isAbort, stuffed, dataBit, byteDone, emit, hasBytes;
  logic [7:0] rawNext, newByte, emitByte;
  assign bitOk    = serBitStrobe && serSlot != 2'd3 && chanEn_reg[serSlot];
  assign modeHdlc = mode_reg != MD_EXT;
  assign rawNext  = {serBit, rawSh_reg[7:1]};
  assign isFlag   = bitOk && modeHdlc && rawNext == FLAG;
  assign isAbort  = bitOk && modeHdlc && serBit && ones_reg == ABORT_ONES;
  assign stuffed  = !serBit && ones_reg == STUFF_ONES;
  assign dataBit  = bitOk && (!modeHdlc || (inFrame_reg && !isFlag && !isAbort && !stuffed));
  assign newByte  = {serBit, byteSh_reg[7:1]};
  assign byteDone = dataBit && bitCnt_reg == 3'd7;
  assign emit     = byteDone && (!modeHdlc || dCnt_reg == 2'd2);
  assign emitByte = modeHdlc ? d1_reg : newByte;
  assign hasBytes = dCnt_reg != 2'd0 || idx_reg != 2'd0;

  // Address comparison with the C/R bit masked out of the SAPI byte.
  logic sapiHit, teiHit, keepNow;
  assign sapiHit = (d1_reg & SAPI_MASK) == (sapi_match_first_reg & SAPI_MASK) ||
                   (d1_reg & SAPI_MASK) == (sapi_match_second_reg & SAPI_MASK) ||
                   (d1_reg & SAPI_MASK) == GRP_SAPI;
  assign teiHit  = d1_reg[7:1] == tei_match_first_reg[7:1] || d1_reg[7:1] == tei_match_second_reg[7:1] ||
                   d1_reg[7:1] == GRP_TEI;
  always_comb begin
    unique case (mode_reg)
      MD_EXT, MD_TRANS: keepNow = 1'b1;
      MD_ONE, MD_SAPI:  keepNow = idx_reg >= 2'd1 && addrPass_reg;
      MD_TWO, MD_TEI:   keepNow = idx_reg >= 2'd2 && addrPass_reg;
      default:          keepNow = 1'b0;
    endcase
  end

  // Deframer state; a receiver reset returns it to hunting for a flag.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rawSh_reg <= 8'h00; ones_reg <= 3'h0; inFrame_reg <= 1'b0; byteSh_reg <= 8'h00;
      bitCnt_reg <= 3'h0; d0_reg <= 8'h00; d1_reg <= 8'h00; dCnt_reg <= 2'h0;
      crc_reg <= CRC_INIT; idx_reg <= 2'h0; addrPass_reg <= 1'b0; endState_reg <= END_IDLE;
      stVfr_reg <= 1'b0; stCrc_reg <= 1'b0; stAbort_reg <= 1'b0;
    end else if (cmdRres) begin
      rawSh_reg <= 8'h00; ones_reg <= 3'h0; inFrame_reg <= 1'b0; bitCnt_reg <= 3'h0;
      dCnt_reg <= 2'h0; idx_reg <= 2'h0; endState_reg <= END_IDLE;
    end else begin
      if (bitOk) begin
        rawSh_reg <= rawNext;
        ones_reg  <= !serBit ? 3'h0 : (ones_reg == 3'h7 ? 3'h7 : ones_reg + 3'h1);
      end
      unique case (endState_reg)
        END_CRC1: endState_reg <= END_CRC2;
        END_CRC2: endState_reg <= END_STAT;
        END_STAT: endState_reg <= END_IDLE;
        END_IDLE: endState_reg <= END_IDLE;
      endcase
      if (isFlag) begin
        // A shared closing flag opens the next frame at once.
        inFrame_reg <= 1'b1; bitCnt_reg <= 3'h0; dCnt_reg <= 2'h0; idx_reg <= 2'h0;
        crc_reg <= CRC_INIT;
        if (inFrame_reg && hasBytes) begin
          endState_reg <= (mode_reg == MD_TRANS && dCnt_reg == 2'd2) ? END_CRC1 : END_STAT;
          stCrc_reg    <= crc_reg == CRC_GOOD;
          stVfr_reg    <= bitCnt_reg == 3'd7;
          stAbort_reg  <= 1'b0;
        end
      end else if (isAbort) begin
        inFrame_reg <= 1'b0;
        if (inFrame_reg && hasBytes) begin
          endState_reg <= END_STAT; stAbort_reg <= 1'b1; stVfr_reg <= 1'b0;
        end
      end else if (dataBit) begin
        byteSh_reg <= newByte;
        bitCnt_reg <= bitCnt_reg + 3'h1;
        if (byteDone) begin
          // Two bytes stay back so that the FCS reaches the FIFO only in MD_TRANS mode.
          d0_reg   <= newByte; d1_reg <= d0_reg;
          dCnt_reg <= (dCnt_reg == 2'd2) ? 2'd2 : dCnt_reg + 2'd1;
          crc_reg  <= crcByte(crc_reg, newByte);
        end
        if (emit && modeHdlc) begin
          idx_reg <= (idx_reg == 2'd2) ? 2'd2 : idx_reg + 2'd1;
          if (idx_reg == 2'd0) begin
            addrPass_reg <= (mode_reg == MD_ONE) ? teiHit :
                            (mode_reg == MD_TWO || mode_reg == MD_SAPI) ? sapiHit : 1'b1;
          end else if (idx_reg == 2'd1 && mode_reg == MD_TWO) begin
            addrPass_reg <= addrPass_reg && teiHit;
          end else if (idx_reg == 2'd1 && mode_reg == MD_TEI) begin
            addrPass_reg <= teiHit;
          end
        end
      end
    end
  end

  // Write side of the FIFO and the indication queue.
  logic [6:0]  used;
  logic [QW:0] qCount;
  logic        qFull, haveSpace, wrStat, crcSt, wrReq, wrOk, firstLost, pushRpf, pushRme;
  logic [5:0]  segInc;
  logic [7:0]  wrData, statByte;
  logic [11:0] cntNext;
  assign used      = wrPtr_reg - relPtr_reg;
  assign qCount    = qWr_reg - qRd_reg;
  assign qFull     = qCount == (QW+1)'(QDEPTH);
  assign haveSpace = used != FIFO_BYTES && !qFull;
  assign wrStat    = endState_reg == END_STAT && started_reg && !frameDrop_reg;
  assign crcSt     = endState_reg == END_CRC1 || endState_reg == END_CRC2;
  assign wrReq     = (emit && keepNow) || crcSt || wrStat;
  assign wrOk      = wrReq && !frameDrop_reg && haveSpace;
  assign firstLost = wrReq && modeHdlc && !started_reg && !frameDrop_reg && !haveSpace;
  assign segInc    = segCnt_reg + 6'd1;
  assign pushRpf   = wrOk && !wrStat && segInc == blkSize_reg;
  assign pushRme   = wrStat && !qFull && (wrOk || segCnt_reg != 6'd0);
  assign statByte  = {stVfr_reg && !stAbort_reg, rdo_reg, stCrc_reg, stAbort_reg, 4'h0};
  assign wrData    = endState_reg == END_CRC1 ? d1_reg : endState_reg == END_CRC2 ? d0_reg :
                     wrStat ? statByte : emitByte;
  assign cntNext   = (wrOk && frameCnt_reg != CNT_MAX) ? frameCnt_reg + 12'd1 : frameCnt_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= 7'h00; segCnt_reg <= 6'h00; frameCnt_reg <= 12'h000; frameOv_reg <= 1'b0;
      qWr_reg <= '0; started_reg <= 1'b0; frameDrop_reg <= 1'b0; rdo_reg <= 1'b0;
    end else if (cmdRres) begin
      wrPtr_reg <= 7'h00; segCnt_reg <= 6'h00; frameCnt_reg <= 12'h000; frameOv_reg <= 1'b0;
      qWr_reg <= '0; started_reg <= 1'b0; frameDrop_reg <= 1'b0; rdo_reg <= 1'b0;
    end else begin
      if (wrOk) begin
        mem_reg[wrPtr_reg[5:0]] <= wrData;
        wrPtr_reg    <= wrPtr_reg + 7'h01;
        segCnt_reg   <= (pushRpf || wrStat) ? 6'h00 : segInc;
        frameCnt_reg <= cntNext;
        if (frameCnt_reg == CNT_MAX) frameOv_reg <= 1'b1;
      end
      if (pushRpf || pushRme) begin
        qEnd_reg[qWr_reg[QW-1:0]] <= pushRme;
        qLen_reg[qWr_reg[QW-1:0]] <= wrOk ? segInc : segCnt_reg;
        qCnt_reg[qWr_reg[QW-1:0]] <= cntNext;
        qOv_reg[qWr_reg[QW-1:0]]  <= frameOv_reg || (wrOk && frameCnt_reg == CNT_MAX);
        qWr_reg <= qWr_reg + (QW+1)'(1);
      end
      if (wrReq && modeHdlc) started_reg <= 1'b1;
      if (firstLost) frameDrop_reg <= 1'b1;
      if (wrReq && started_reg && !frameDrop_reg && !haveSpace && !wrStat) rdo_reg <= 1'b1;
      if (endState_reg == END_STAT) begin
        started_reg <= 1'b0; frameDrop_reg <= 1'b0; rdo_reg <= 1'b0;
        segCnt_reg <= 6'h00; frameCnt_reg <= 12'h000; frameOv_reg <= 1'b0;
      end
    end
  end

  // Host side: one queued block at a time is shown, released by block-done.
  logic present;
  assign present = !presented_reg && qCount != '0 && !cmdRmc && !cmdRres;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPtr_reg <= 7'h00; relPtr_reg <= 7'h00; qRd_reg <= '0; presented_reg <= 1'b0;
      curLen_reg <= 6'h00; curEnd_reg <= 1'b0; cnt_reg <= 12'h000; cntOv_reg <= 1'b0;
      blkSize_reg <= BLK_MAX; lastByte_reg <= 8'h00;
    end else if (cmdRres) begin
      rdPtr_reg <= 7'h00; relPtr_reg <= 7'h00; qRd_reg <= '0; presented_reg <= 1'b0;
      cnt_reg <= 12'h000; cntOv_reg <= 1'b0;
      blkSize_reg <= BLK_MAX >> blkSel_reg;
    end else if (cmdRmc) begin
      blkSize_reg <= BLK_MAX >> blkSel_reg;
      if (presented_reg) begin
        // Unread bytes of the block are dropped with it.
        relPtr_reg <= relPtr_reg + {1'b0, curLen_reg};
        rdPtr_reg  <= relPtr_reg + {1'b0, curLen_reg};
        qRd_reg    <= qRd_reg + (QW+1)'(1);
        presented_reg <= 1'b0;
        if (curEnd_reg) begin
          cnt_reg <= 12'h000; cntOv_reg <= 1'b0;
        end
      end
    end else if (present) begin
      presented_reg <= 1'b1;
      curLen_reg <= qLen_reg[qRd_reg[QW-1:0]];
      curEnd_reg <= qEnd_reg[qRd_reg[QW-1:0]];
      cnt_reg    <= qCnt_reg[qRd_reg[QW-1:0]];
      cntOv_reg  <= qOv_reg[qRd_reg[QW-1:0]];
      rdPtr_reg  <= relPtr_reg;
    end else if (fifoRd && canRead) begin
      rdPtr_reg    <= rdPtr_reg + 7'h01;
      lastByte_reg <= mem_reg[rdPtr_reg[5:0]];
    end
  end

  // Indication flags: RME and RPF set on presentation, RFO on a lost frame; cleared by reading; a set wins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      istat_reg <= 3'h0;
    end else begin
      istat_reg <= (istatRd ? 3'h0 : istat_reg) |
                   {present && !qEnd_reg[qRd_reg[QW-1:0]], present && qEnd_reg[qRd_reg[QW-1:0]],
                    firstLost};
    end
  end

  // Software-written configuration.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chanEn_reg <= CHAN_RST; mode_reg <= MODE_RST; blkSel_reg <= BLK_RST;
      sapi_match_first_reg <= 8'h00; sapi_match_second_reg <= 8'h00; tei_match_first_reg <= 8'h00; tei_match_second_reg <= 8'h00;
    end else if (doWrite && wLane_reg) begin
      unique case (awIdx_reg)
        IDX_CHAN: chanEn_reg <= wData_reg[2:0];
        IDX_MODE: mode_reg   <= wData_reg[2:0];
        IDX_SAPI_MATCH_FIRST: sapi_match_first_reg   <= wData_reg;
        IDX_SAPI_MATCH_SECOND: sapi_match_second_reg   <= wData_reg;
        IDX_TEI_MATCH_FIRST: tei_match_first_reg   <= wData_reg;
        IDX_TEI_MATCH_SECOND: tei_match_second_reg   <= wData_reg;
        IDX_EXTENDED_FIFO_CONFIG: blkSel_reg <= wData_reg[1:0];
        default: ;
      endcase
    end
  end

  // AXI4-Lite write channels: address and data taken in either order.
  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready  = !wHeld_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awHeld_reg <= 1'b0; wHeld_reg <= 1'b0; awIdx_reg <= 6'h00; wData_reg <= 8'h00;
      wCmd_reg <= 2'h0; wLane_reg <= 1'b0; s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid && !awHeld_reg) begin
        awHeld_reg <= 1'b1; awIdx_reg <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !wHeld_reg) begin
        wHeld_reg <= 1'b1; wData_reg <= s_axi_wdata[7:0];
        wCmd_reg <= s_axi_wdata[1:0]; wLane_reg <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0; wHeld_reg <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OK : RESP_SLV;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel; a FIFO slot read past the data repeats the last byte.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= RESP_OK;
    end else if (doRead) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OK;
      if (arIdx <= IDX_FIFO_LAST) begin
        s_axi_rdata <= {24'h0, canRead ? mem_reg[rdPtr_reg[5:0]] : lastByte_reg};
      end else begin
        unique case (arIdx)
          IDX_CHAN:  s_axi_rdata <= {29'h0, chanEn_reg};
          IDX_MODE:  s_axi_rdata <= {29'h0, mode_reg};
          IDX_SAPI_MATCH_FIRST:  s_axi_rdata <= {24'h0, sapi_match_first_reg};
          IDX_SAPI_MATCH_SECOND:  s_axi_rdata <= {24'h0, sapi_match_second_reg};
          IDX_TEI_MATCH_FIRST:  s_axi_rdata <= {24'h0, tei_match_first_reg};
          IDX_TEI_MATCH_SECOND:  s_axi_rdata <= {24'h0, tei_match_second_reg};
          IDX_EXTENDED_FIFO_CONFIG:  s_axi_rdata <= {30'h0, blkSel_reg};
          IDX_ISTAT: s_axi_rdata <= {29'h0, istat_reg};
          IDX_CMD:   s_axi_rdata <= 32'h0;
          IDX_CNTL:  s_axi_rdata <= {24'h0, cnt_reg[7:0]};
          IDX_CNTH:  s_axi_rdata <= {27'h0, cntOv_reg, cnt_reg[11:8]};
          default: begin
            s_axi_rdata <= 32'h0; s_axi_rresp <= RESP_SLV;
          end
        endcase
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the framer and the block protocol.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence sRelease;
    cmdRmc && presented_reg;
  endsequence
  sequence sFifoRead;
    fifoRd && canRead && !cmdRmc && !cmdRres && !present;
  endsequence
  AST_FIFO_ALIAS: assert property (sFifoRead |=> rdPtr_reg == $past(rdPtr_reg) + 7'h01)
    else $error("FIFO read did not advance the pointer");
  AST_NO_OVERFILL: assert property (used <= FIFO_BYTES)
    else $error("FIFO holds more than its capacity");
  AST_CHAN_GATE: assert property (serBitStrobe && !bitOk && !cmdRres |=> $stable(rawSh_reg))
    else $error("Bit taken from a disabled channel");
  AST_RPF_BLOCK: assert property (pushRpf |-> segInc == blkSize_reg && !wrStat)
    else $error("Pool-full queued before a whole block");
  AST_RFO_FLAG: assert property (firstLost |=> istat_reg[IS_RFO] && frameDrop_reg)
    else $error("Lost frame not flagged");
  AST_RMC_FREE: assert property (sRelease |=> relPtr_reg == $past(relPtr_reg) +
    {1'b0, $past(curLen_reg)} && !presented_reg)
    else $error("Block-done did not release the block");
  AST_RX_RESET_CMD_KEEP: assert property (cmdRres && !istatRd |=>
    (istat_reg & $past(istat_reg)) == $past(istat_reg) && used == 7'h00)
    else $error("Receiver reset lost a flag or kept data");
  AST_CNT_OV: assert property (wrOk && frameCnt_reg == CNT_MAX && endState_reg != END_STAT
    |=> frameOv_reg)
    else $error("Count overflow not set");
  AST_BLK_LOAD: assert property (!$stable(blkSize_reg) |-> $past(cmdRmc || cmdRres))
    else $error("Block size changed without a command");
  AST_STAT_END: assert property (wrStat && wrOk |-> pushRme ##1 segCnt_reg == 6'h00)
    else $error("Status byte not closing a message");
  AST_NEXT_IND: assert property (sRelease ##1 qCount != '0 && !cmdRmc && !cmdRres
    |-> ##1 presented_reg)
    else $error("Queued indication not presented");
  AST_HOLD_LAST: assert property (fifoRd && !canRead && !cmdRmc && !cmdRres && !present
    |=> s_axi_rdata[7:0] == $past(lastByte_reg) && $stable(rdPtr_reg))
    else $error("Over-read changed data or pointer");
endmodule : lhr_receiver
`default_nettype wire

// ### lhr_line_model.sv
/* Line-side frame source for the LAPD receiver bench.
   Assumes the receiver samples serBit at serBitStrobe on clk. */
`timescale 1ns/1ps
`default_nettype none
module lhr_line_model (
  input  wire logic  clk,
  output logic       serBit,
  output logic [1:0] serSlot,
  output logic       serBitStrobe
);
  int ones;
  // The line idles at ones with no strobes, so nothing is framed between calls.
  initial {serBit, serSlot, serBitStrobe} = 4'h8;
  // Strobes sit four clocks apart, twice the minimum spacing the receiver needs.
  task automatic put(input logic b);
    @(posedge clk);
    serBit       <= b;
    serBitStrobe <= 1'b1;
    @(posedge clk);
    serBitStrobe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : put
  // Bits go LSB first; a zero follows five ones so data never looks like a flag.
  task automatic put_byte(input logic [7:0] b, input bit stuff);
    for (int i = 0; i < 8; i++) begin
      put(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        put(1'b0);
        ones = 0;
      end
    end
  endtask : put_byte
  // Flag, payload, inverted reflected CRC-16 low byte first, flag, idle.
  task automatic send_frame(input logic [1:0] slot, input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    serSlot <= slot;
    ones = 0;
    put_byte(8'h7e, 1'b0);
    foreach (q[k]) begin
      put_byte(q[k], 1'b1);
      for (int j = 0; j < 8; j++) c = (c[0] ^ q[k][j]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    c = ~c;
    put_byte(c[7:0], 1'b1);
    put_byte(c[15:8], 1'b1);
    put_byte(8'h7e, 1'b0);
    serBit <= 1'b1;
  endtask : send_frame
endmodule : lhr_line_model
`default_nettype wire

// ### testbench.sv
/* Self-checking bench for lhr_receiver over AXI4-Lite with a line frame source.
   Assumes the register map and status byte layout of the receiver package. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import lhr_pkg::*;
  logic        clk = 1'b0, reset_n = 1'b0, serBit, serBitStrobe, awR, wR, bV, arR, rV;
  logic        awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
  logic [1:0]  serSlot, rRsp, r;
  logic [7:0]  awA = 8'h00, arA = 8'h00, v;
  logic [31:0] wD = 32'h0, rD;
  logic [3:0]  wS = 4'h1;
  int          errors = 0, checksDone = 0;
  lhr_receiver uut (.clk(clk), .reset_n(reset_n), .serBit(serBit), .serSlot(serSlot),
    .serBitStrobe(serBitStrobe), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR),
    .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV), .s_axi_wready(wR),
    .s_axi_bresp(), .s_axi_bvalid(bV), .s_axi_bready(bRdy), .s_axi_araddr(arA),
    .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRsp),
    .s_axi_rvalid(rV), .s_axi_rready(rRdy));
  lhr_line_model lm (.clk(clk), .serBit(serBit), .serSlot(serSlot), .serBitStrobe(serBitStrobe));
  always #2.5 clk = ~clk;
  // Each channel drops its valid at the edge its ready is seen; waits end only by watchdog.
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    {awA, awV, wD, wV, bRdy} <= {i, 2'b00, 1'b1, 24'h0, d, 1'b1, 1'b1};
    do begin
      @(posedge clk);
      if (awR) awV <= 1'b0;
      if (wR) wV <= 1'b0;
    end while (!bV);
    bRdy <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] i, output logic [7:0] d);
    @(posedge clk);
    {arA, arV, rRdy} <= {i, 2'b00, 1'b1, 1'b1};
    do begin
      @(posedge clk);
      if (arR) arV <= 1'b0;
    end while (!rV);
    {d, r} = {rD[7:0], rRsp};
    rRdy <= 1'b0;
  endtask : rd
  // Polling stands in for the interrupt line, which this block does not have.
  task automatic ind(input logic [7:0] e);
    v = 8'h00;
    while (v == 8'h00) rd(IDX_ISTAT, v);
    `CHK(v, e)
  endtask : ind
  // Walking down from the top slot shows the top four FIFO addresses reach the same pointer.
  task automatic fifo(input logic [7:0] q[$]);
    foreach (q[k]) begin
      rd(IDX_FIFO_LAST - 6'(k), v);
      `CHK(v, q[k])
    end
  endtask : fifo
  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    errors++;
    complete_run;
  end
  // Reset values, then five frame scenarios in modes 011, 111, 101 and 010.
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(IDX_MODE, v); `CHK(v, 8'h03)
    rd(IDX_EXTENDED_FIFO_CONFIG, v); `CHK(v, 8'h00)
    rd(6'h2b, v); `CHK(r, RESP_SLV)
    $display("Test reset values done");
    lm.send_frame(2'h0, '{8'h02, 8'hff, 8'h11, 8'h22, 8'h33});
    ind(8'h02);
    rd(IDX_CNTL, v); `CHK(v, 8'h04)
    fifo('{8'h11, 8'h22, 8'h33, 8'ha0});
    wr(IDX_CMD, 8'h01);
    $display("Test short frame done");
    wr(IDX_EXTENDED_FIFO_CONFIG, 8'h03);
    wr(IDX_CMD, 8'h02);
    lm.send_frame(2'h0, '{8'h00, 8'hff, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06});
    ind(8'h04);
    fifo('{8'h01, 8'h02, 8'h03, 8'h04});
    wr(IDX_CMD, 8'h01);
    ind(8'h02);
    rd(IDX_CNTL, v); `CHK(v, 8'h07)
    fifo('{8'h05, 8'h06, 8'ha0});
    wr(IDX_CMD, 8'h01);
    $display("Test block split done");
    wr(IDX_MODE, 8'h07);
    wr(IDX_CMD, 8'h02);
    lm.send_frame(2'h1, '{8'hfe, 8'h77});
    lm.send_frame(2'h0, '{8'h10, 8'h77});
    lm.send_frame(2'h0, '{8'hfe, 8'h55, 8'h66});
    ind(8'h02);
    rd(IDX_CNTL, v); `CHK(v, 8'h03)
    fifo('{8'h55, 8'h66, 8'ha0});
    rd(IDX_FIFO_LAST, v); `CHK(v, 8'ha0)
    wr(IDX_CMD, 8'h01);
    $display("Test SAPI filter done");
    // The second byte alone decides; only the third onwards is stored.
    wr(IDX_MODE, 8'h05);
    wr(IDX_CMD, 8'h02);
    lm.send_frame(2'h0, '{8'h00, 8'hff, 8'h44});
    ind(8'h02);
    rd(IDX_CNTL, v); `CHK(v, 8'h02)
    fifo('{8'h44, 8'ha0});
    wr(IDX_CMD, 8'h01);
    $display("Test TEI filter done");
    // A single address byte is held against the TEI set.
    wr(IDX_MODE, 8'h02);
    wr(IDX_CMD, 8'h02);
    lm.send_frame(2'h0, '{8'hff, 8'h33});
    ind(8'h02);
    rd(IDX_CNTL, v); `CHK(v, 8'h02)
    fifo('{8'h33, 8'ha0});
    wr(IDX_CMD, 8'h01);
    $display("Test one-byte address done");
    complete_run;
  end
endmodule : testbench
`default_nettype wire
